// ===== pkg/nat_pkg.sv
// Purpose: Shared types for the nibble ALU and table fetch datapath.
// Assumes: nat_regs.svh supplies the widths.
// Notes: Operation codes are this block's own, not an instruction encoding.
`default_nettype none
`include "nat_regs.svh"
package nat_pkg;
  typedef logic [`NAT_NIB_W-1:0] nat_nib_t;
  typedef enum logic [4:0] {
    NAT_OP_NOP, NAT_OP_ADD_MEM, NAT_OP_ADD_MEM_CY, NAT_OP_ADD_IMM, NAT_OP_AND_MEM,
    NAT_OP_OR_MEM, NAT_OP_SET_CY, NAT_OP_CLR_CY, NAT_OP_TEST_CY, NAT_OP_COMPL,
    NAT_OP_ROTATE, NAT_OP_BIT_SET, NAT_OP_BIT_CLR, NAT_OP_BIT_TEST, NAT_OP_LOAD_ACC_IMM,
    NAT_OP_TABLE_FETCH
  } nat_op_e;
  typedef struct packed {
    logic valid;
    nat_op_e op;
    nat_nib_t imm;
    logic [1:0] bit_idx;
  } nat_instr_s;
  typedef enum logic [1:0] {
    NAT_ST_IDLE = 2'h1,
    NAT_ST_FETCH = 2'h2
  } nat_state_e;
endpackage : nat_pkg
`default_nettype wire

// ===== pkg/nat_regs.svh
// Purpose: Named constants for the nibble ALU and table fetch datapath.
// Assumes: Included by bare name from the package and design files.
// Notes: Definitions only.
`ifndef NAT_REGS_SVH
`define NAT_REGS_SVH
`define NAT_NIB_W 4
`define NAT_ROM_W 10
`define NAT_DREG_W 3
`define NAT_PAGE_W 7
`define NAT_ROM_LO_MSB 3
`define NAT_ROM_HI_MSB 7
`define NAT_ROM_HI_LSB 4
`define NAT_ROM_UP_MSB 9
`define NAT_ROM_UP_LSB 8
`define NAT_NIB_ZERO 4'h0
`define NAT_DREG_ZERO 3'h0
`define NAT_ACC_MSB 3
`endif

// ===== src/nat_adder.sv
// Purpose: Four-bit adder with carry in and carry out.
// Assumes: Purely combinational.
// Notes: Shared by every add form of the datapath.
`default_nettype none
`include "nat_regs.svh"
module nat_adder (
  input wire logic [`NAT_NIB_W-1:0] a_in, // First operand.
  input wire logic [`NAT_NIB_W-1:0] b_in, // Second operand.
  input wire logic c_in, // Carry in.
  output logic [`NAT_NIB_W-1:0] sum_out, // Sum.
  output logic c_out // Carry out.
);
  import nat_pkg::*;
  logic [`NAT_NIB_W:0] total;
  always_comb begin
    total = {1'b0, a_in} + {1'b0, b_in} + {{`NAT_NIB_W{1'b0}}, c_in};
    sum_out = total[`NAT_NIB_W-1:0];
    c_out = total[`NAT_NIB_W];
  end
endmodule : nat_adder
`default_nettype wire

// ===== src/nat_bit_unit.sv
// Purpose: Bit set, clear and test on a memory nibble.
// Assumes: Purely combinational.
// Notes: The decoded mask is reused by all three operations.
`default_nettype none
`include "nat_regs.svh"
module nat_bit_unit (
  input wire logic [`NAT_NIB_W-1:0] nib_in, // Nibble under operation.
  input wire logic [1:0] idx_in, // Bit index j.
  output logic [`NAT_NIB_W-1:0] set_out, // Nibble with bit j set.
  output logic [`NAT_NIB_W-1:0] clr_out, // Nibble with bit j cleared.
  output logic bit_out // Value of bit j.
);
  import nat_pkg::*;
  function automatic logic [`NAT_NIB_W-1:0] decode_mask(input logic [1:0] idx);
    decode_mask = `NAT_NIB_ZERO;
    decode_mask[idx] = 1'b1;
  endfunction : decode_mask
  logic [`NAT_NIB_W-1:0] mask;
  always_comb begin
    mask = decode_mask(idx_in);
    set_out = nib_in | mask;
    clr_out = nib_in & ~mask;
    bit_out = |(nib_in & mask);
  end
endmodule : nat_bit_unit
`default_nettype wire

// ===== src/nat_datapath.sv
// Purpose: Accumulator ALU, carry and bit operations, skip control and ROM table fetch.
// Assumes: One instruction offered per cycle on instr_in; memory and ROM reads are combinational.
// Notes: Table fetch takes two cycles and stalls the sequencer through busy_out.
`default_nettype none
`include "nat_regs.svh"
module nat_datapath #(
  parameter int PAGE_W = `NAT_PAGE_W // Width of the table page number.
) (
  input wire logic sys_clk_in, // Instruction clock.
  input wire logic reset_n_in, // Asynchronous reset, active low.
  input wire nat_pkg::nat_instr_s instr_in, // Decoded instruction, one per slot.
  input wire logic [PAGE_W-1:0] page_in, // Table page p.
  input wire logic upper_table_fetch_flag_in, // Upper table fetch enable.
  input wire logic [`NAT_NIB_W-1:0] pointed_memory_nibble_in, // Nibble at the data pointer.
  input wire logic [`NAT_ROM_W-1:0] rom_data_in, // ROM word at rom_addr_out.
  output logic [`NAT_NIB_W-1:0] acc_out, // Accumulator.
  output logic carry_flag_out, // Carry flag.
  output logic [`NAT_NIB_W-1:0] reg_b_out, // Register B.
  output logic [`NAT_DREG_W-1:0] reg_d_out, // Register D.
  output logic mem_we_out, // Write strobe for the data pointer nibble.
  output logic [`NAT_NIB_W-1:0] mem_wdata_out, // Data for that write.
  output logic [PAGE_W+`NAT_DREG_W+`NAT_NIB_W-1:0] rom_addr_out, // Table address.
  output logic return_stack_push_out, // Claims one return stack level.
  output logic return_stack_pop_out, // Releases that level.
  output logic skip_out, // The instruction now offered is skipped.
  output logic busy_out // Table fetch in progress, hold the next instruction.
);
  import nat_pkg::*;

  // ---------------------------------------------------------------
  // Arithmetic and bit units
  // ---------------------------------------------------------------
  logic [`NAT_NIB_W-1:0] add_b;
  logic add_cin;
  logic [`NAT_NIB_W-1:0] add_sum;
  logic add_cout;
  logic [`NAT_NIB_W-1:0] bit_set_val;
  logic [`NAT_NIB_W-1:0] bit_clr_val;
  logic bit_val;
  logic [`NAT_NIB_W-1:0] acc_q, acc_d;
  logic carry_q, carry_d;
  logic [`NAT_NIB_W-1:0] reg_b_q, reg_b_d;
  logic [`NAT_DREG_W-1:0] reg_d_q, reg_d_d;
  logic skip_q, skip_d;
  logic last_load_q, last_load_d;
  logic mem_we_q, mem_we_d;
  logic [`NAT_NIB_W-1:0] mem_wdata_q, mem_wdata_d;
  nat_state_e state_q, state_d;
  logic exec;

  always_comb begin
    add_b = pointed_memory_nibble_in;
    add_cin = 1'b0;
    if (instr_in.op == NAT_OP_ADD_IMM) begin
      add_b = instr_in.imm;
    end
    if (instr_in.op == NAT_OP_ADD_MEM_CY) begin
      add_cin = carry_q;
    end
  end

  nat_adder u_adder (
    .a_in(acc_q),
    .b_in(add_b),
    .c_in(add_cin),
    .sum_out(add_sum),
    .c_out(add_cout)
  );

  nat_bit_unit u_bit (
    .nib_in(pointed_memory_nibble_in),
    .idx_in(instr_in.bit_idx),
    .set_out(bit_set_val),
    .clr_out(bit_clr_val),
    .bit_out(bit_val)
  );

  // ---------------------------------------------------------------
  // Execution
  // ---------------------------------------------------------------
  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  // These tests are shared by the skip logic, the execution case and the outputs.
  function automatic logic is_load(input nat_op_e op);
    is_load = (op == NAT_OP_LOAD_ACC_IMM);
  endfunction : is_load

  function automatic logic is_fetch(input nat_op_e op);
    is_fetch = (op == NAT_OP_TABLE_FETCH);
  endfunction : is_fetch

  function automatic logic is_idle(input nat_state_e st);
    is_idle = (st == NAT_ST_IDLE);
  endfunction : is_idle

  // ---------------------------------------------------------------
  // Skip control
  // ---------------------------------------------------------------
  logic load_run;

  // repeated load run
  // Only a load that directly follows a load is dropped; any other instruction
  // after a load must run, so the run is judged on the slot now offered
  // instead of arming a skip in advance.
  assign load_run = instr_in.valid && last_load_q && is_load(instr_in.op) && is_idle(state_q);

  assign exec = instr_in.valid && !skip_q && !load_run && is_idle(state_q);

  always_comb begin
    acc_d = acc_q;
    carry_d = carry_q;
    reg_b_d = reg_b_q;
    reg_d_d = reg_d_q;
    skip_d = skip_q;
    last_load_d = last_load_q;
    mem_we_d = 1'b0;
    mem_wdata_d = mem_wdata_q;
    state_d = state_q;
    case (state_q)
      NAT_ST_IDLE: begin
        if (instr_in.valid) begin
          // A skip covers exactly one offered slot.
          skip_d = 1'b0;
          last_load_d = is_load(instr_in.op);
        end
        if (exec) begin
          case (instr_in.op)
            NAT_OP_ADD_MEM: acc_d = add_sum;
            NAT_OP_ADD_MEM_CY: begin
              acc_d = add_sum;
              carry_d = add_cout;
            end
            NAT_OP_ADD_IMM: begin
              acc_d = add_sum;
              skip_d = !add_cout;
            end
            NAT_OP_AND_MEM: acc_d = acc_q & pointed_memory_nibble_in;
            NAT_OP_OR_MEM: acc_d = acc_q | pointed_memory_nibble_in;
            NAT_OP_SET_CY: carry_d = 1'b1;
            NAT_OP_CLR_CY: carry_d = 1'b0;
            NAT_OP_TEST_CY: skip_d = !carry_q;
            NAT_OP_COMPL: acc_d = ~acc_q;
            NAT_OP_ROTATE: begin
              acc_d = {carry_q, acc_q[`NAT_ACC_MSB:1]};
              carry_d = acc_q[0];
            end
            NAT_OP_BIT_SET: begin
              mem_we_d = 1'b1;
              mem_wdata_d = bit_set_val;
            end
            NAT_OP_BIT_CLR: begin
              mem_we_d = 1'b1;
              mem_wdata_d = bit_clr_val;
            end
            NAT_OP_BIT_TEST: skip_d = !bit_val;
            NAT_OP_LOAD_ACC_IMM: acc_d = instr_in.imm;
            NAT_OP_TABLE_FETCH: state_d = NAT_ST_FETCH;
            default: acc_d = acc_q;
          endcase
        end
      end
      NAT_ST_FETCH: begin
        // The ROM word is taken in the second cycle, once its address has
        // settled from registers; the cost is one busy slot per fetch.
        // deliver ROM word
        reg_b_d = rom_data_in[`NAT_ROM_HI_MSB:`NAT_ROM_HI_LSB];
        acc_d = rom_data_in[`NAT_ROM_LO_MSB:0];
        if (upper_table_fetch_flag_in) begin
          reg_d_d = {1'b0, rom_data_in[`NAT_ROM_UP_MSB:`NAT_ROM_UP_LSB]};
        end
        state_d = NAT_ST_IDLE;
      end
      default: state_d = NAT_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_q <= `NAT_NIB_ZERO;
      carry_q <= 1'b0;
      reg_b_q <= `NAT_NIB_ZERO;
      reg_d_q <= `NAT_DREG_ZERO;
      skip_q <= 1'b0;
      last_load_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= `NAT_NIB_ZERO;
      state_q <= NAT_ST_IDLE;
    end else begin
      acc_q <= acc_d;
      carry_q <= carry_d;
      reg_b_q <= reg_b_d;
      reg_d_q <= reg_d_d;
      skip_q <= skip_d;
      last_load_q <= last_load_d;
      mem_we_q <= mem_we_d;
      mem_wdata_q <= mem_wdata_d;
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // table address
  assign rom_addr_out = {page_in, reg_d_q, acc_q};
  assign return_stack_push_out = exec && is_fetch(instr_in.op);
  assign return_stack_pop_out = (state_q == NAT_ST_FETCH);
  assign busy_out = (state_q == NAT_ST_FETCH);
  assign skip_out = skip_q || load_run;
  assign acc_out = acc_q;
  assign carry_flag_out = carry_q;
  assign reg_b_out = reg_b_q;
  assign reg_d_out = reg_d_q;
  assign mem_we_out = mem_we_q;
  assign mem_wdata_out = mem_wdata_q;
endmodule : nat_datapath
`default_nettype wire

// ===== test/nat_datapath_sva.sv
// Purpose: Port-level checks of nat_datapath.
// Assumes: Bound to every nat_datapath instance.
// Notes: A slot executes when taken while skip_out is low.
`default_nettype none
module nat_datapath_sva
  import nat_pkg::*;
#(
  parameter int PAGE_W = 7
) (
  input wire logic sys_clk_in, // Clock.
  input wire logic reset_n_in, // Reset, active low.
  input wire nat_pkg::nat_instr_s instr_in, // Slot.
  input wire logic [PAGE_W-1:0] page_in, // Page.
  input wire logic [3:0] pointed_memory_nibble_in, // Memory nibble.
  input wire logic [3:0] acc_out, // Accumulator.
  input wire logic carry_flag_out, // Carry.
  input wire logic [2:0] reg_d_out, // Register D.
  input wire logic mem_we_out, // Write strobe.
  input wire logic [3:0] mem_wdata_out, // Write data.
  input wire logic [PAGE_W+6:0] rom_addr_out, // Table address.
  input wire logic return_stack_push_out, // Push.
  input wire logic return_stack_pop_out, // Pop.
  input wire logic skip_out, // Skip.
  input wire logic busy_out // Busy.
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  wire logic go = instr_in.valid && !busy_out && !skip_out;
  wire logic [4:0] imm_sum = {1'b0, acc_out} + {1'b0, instr_in.imm};
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  property p_push; return_stack_push_out |=> return_stack_pop_out && busy_out; endproperty
  a_push: assert property (p_push) else $error("push without pop");
  property p_busy; busy_out |=> !busy_out; endproperty
  a_busy: assert property (p_busy) else $error("busy too long");
  property p_setcy; go && instr_in.op == NAT_OP_SET_CY |=> carry_flag_out && $stable(acc_out); endproperty
  a_setcy: assert property (p_setcy) else $error("set carry wrong");
  property p_clrcy; go && instr_in.op == NAT_OP_CLR_CY |=> !carry_flag_out && $stable(acc_out); endproperty
  a_clrcy: assert property (p_clrcy) else $error("clear carry wrong");
  property p_compl; go && instr_in.op == NAT_OP_COMPL |=> acc_out == ~$past(acc_out); endproperty
  a_compl: assert property (p_compl) else $error("complement wrong");
  property p_addimm; go && instr_in.op == NAT_OP_ADD_IMM |=> acc_out == $past(imm_sum[3:0])
    && skip_out == !$past(imm_sum[4]) && $stable(carry_flag_out); endproperty
  a_addimm: assert property (p_addimm) else $error("add immediate wrong");
  property p_skip; instr_in.valid && !busy_out && skip_out |=> $stable(acc_out) && !mem_we_out; endproperty
  a_skip: assert property (p_skip) else $error("skipped slot wrote");
  property p_bset; go && instr_in.op == NAT_OP_BIT_SET |=> mem_we_out
    && mem_wdata_out == ($past(pointed_memory_nibble_in) | (4'h1 << $past(instr_in.bit_idx))); endproperty
  a_bset: assert property (p_bset) else $error("bit set wrong");
  property p_addr; rom_addr_out == {page_in, reg_d_out, acc_out}; endproperty
  a_addr: assert property (p_addr) else $error("table address wrong");
  property p_ldrun; go && instr_in.op == NAT_OP_LOAD_ACC_IMM ##1 instr_in.valid && !busy_out
    && instr_in.op == NAT_OP_LOAD_ACC_IMM |-> skip_out; endproperty
  a_ldrun: assert property (p_ldrun) else $error("repeated load ran");
  property p_ldend; go && instr_in.op == NAT_OP_LOAD_ACC_IMM ##1 instr_in.valid && !busy_out
    && instr_in.op != NAT_OP_LOAD_ACC_IMM |-> !skip_out; endproperty
  a_ldend: assert property (p_ldend) else $error("slot after load skipped");
endmodule : nat_datapath_sva
bind nat_datapath nat_datapath_sva #(.PAGE_W(PAGE_W)) u_sva (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .instr_in(instr_in), .page_in(page_in), .pointed_memory_nibble_in(pointed_memory_nibble_in), .acc_out(acc_out),
  .carry_flag_out(carry_flag_out), .reg_d_out(reg_d_out), .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out),
  .rom_addr_out(rom_addr_out), .return_stack_push_out(return_stack_push_out),
  .return_stack_pop_out(return_stack_pop_out), .skip_out(skip_out), .busy_out(busy_out));
`default_nettype wire

// ===== test/testbench.sv
// Purpose: Self-checking bench for nat_datapath.
// Assumes: Memory and ROM words are driven by the bench.
// Notes: Checks wait one slot so the result has landed, two for a fetch's ROM word; a fetch's push and address checks are taken in the offered slot.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nat_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  nat_instr_s instr_in = '0;
  logic [6:0] page_in = 7'h55;
  logic upper_table_fetch_flag_in = 1'b1;
  logic [3:0] pointed_memory_nibble_in = 4'h0;
  logic [9:0] rom_data_in = 10'h0;
  logic [3:0] acc_out, reg_b_out, mem_wdata_out;
  logic [2:0] reg_d_out;
  logic [13:0] rom_addr_out;
  logic carry_flag_out, mem_we_out, push, pop, skip_out, busy_out;
  int err_count = 0;
  int n_checks = 0;
  always #4 sys_clk_in = ~sys_clk_in;
  nat_datapath u_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .instr_in(instr_in), .page_in(page_in),
    .upper_table_fetch_flag_in(upper_table_fetch_flag_in), .pointed_memory_nibble_in(pointed_memory_nibble_in),
    .rom_data_in(rom_data_in), .acc_out(acc_out), .carry_flag_out(carry_flag_out), .reg_b_out(reg_b_out),
    .reg_d_out(reg_d_out), .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out), .rom_addr_out(rom_addr_out),
    .return_stack_push_out(push), .return_stack_pop_out(pop), .skip_out(skip_out), .busy_out(busy_out));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic op(input nat_op_e o, input logic [3:0] imm = 4'h0, input logic [3:0] nib = 4'h0,
    input logic [1:0] j = 2'h0);
    @(posedge sys_clk_in);
    instr_in <= '{1'b1, o, imm, j};
    pointed_memory_nibble_in <= nib;
  endtask : op
  task automatic idle();
    @(posedge sys_clk_in);
    instr_in <= '0;
    #1;
  endtask : idle
  task automatic acc_cy(input logic [3:0] a, input logic c);
    idle();
    chk("acc", a, acc_out);
    chk("carry", c, carry_flag_out);
  endtask : acc_cy
  task automatic fetch(input logic [13:0] addr, input logic [9:0] rom, input logic flag, input logic [2:0] d);
    op(NAT_OP_TABLE_FETCH);
    rom_data_in <= rom;
    upper_table_fetch_flag_in <= flag;
    #1;
    chk("push", 1'b1, push);
    chk("addr", addr, rom_addr_out);
    idle();
    chk("pop", 1'b1, pop);
    chk("busy", 1'b1, busy_out);
    @(posedge sys_clk_in);
    #1;
    chk("acc", rom[3:0], acc_out);
    chk("b", rom[7:4], reg_b_out);
    chk("d", d, reg_d_out);
  endtask : fetch
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic s_arith();
    op(NAT_OP_SET_CY);
    op(NAT_OP_LOAD_ACC_IMM, 4'h5);
    op(NAT_OP_NOP);
    op(NAT_OP_ADD_MEM, 4'h0, 4'hc);
    acc_cy(4'h1, 1'b1);
    op(NAT_OP_ADD_MEM_CY, 4'h0, 4'he);
    acc_cy(4'h0, 1'b1);
    op(NAT_OP_CLR_CY);
    op(NAT_OP_ADD_MEM_CY, 4'h0, 4'h3);
    acc_cy(4'h3, 1'b0);
    op(NAT_OP_ADD_IMM, 4'hf);
    acc_cy(4'h2, 1'b0);
    chk("skip", 1'b0, skip_out);
    op(NAT_OP_ADD_IMM, 4'h1);
    acc_cy(4'h3, 1'b0);
    chk("skip", 1'b1, skip_out);
    op(NAT_OP_COMPL);
    acc_cy(4'h3, 1'b0);
    op(NAT_OP_COMPL);
    acc_cy(4'hc, 1'b0);
  endtask : s_arith
  task automatic s_logic();
    op(NAT_OP_AND_MEM, 4'h0, 4'ha);
    acc_cy(4'h8, 1'b0);
    op(NAT_OP_OR_MEM, 4'h0, 4'h3);
    op(NAT_OP_SET_CY);
    op(NAT_OP_ROTATE);
    acc_cy(4'hd, 1'b1);
    op(NAT_OP_CLR_CY);
    op(NAT_OP_ROTATE);
    acc_cy(4'h6, 1'b1);
    op(NAT_OP_TEST_CY);
    op(NAT_OP_COMPL);
    acc_cy(4'h9, 1'b1);
    op(NAT_OP_CLR_CY);
    op(NAT_OP_TEST_CY);
    op(NAT_OP_COMPL);
    acc_cy(4'h9, 1'b0);
  endtask : s_logic
  task automatic s_bits();
    for (int j = 0; j < 4; j++) begin
      op(NAT_OP_BIT_SET, 4'h0, 4'h0, 2'(j));
      idle();
      chk("we", 1'b1, mem_we_out);
      chk("wdata", 4'(4'h1 << j), mem_wdata_out);
      op(NAT_OP_BIT_CLR, 4'h0, 4'hf, 2'(j));
      idle();
      chk("wdata", 4'(~(4'h1 << j)), mem_wdata_out);
      op(NAT_OP_BIT_TEST, 4'h0, ~(4'h1 << j), 2'(j));
      op(NAT_OP_COMPL);
      op(NAT_OP_BIT_TEST, 4'h0, 4'hf, 2'(j));
      op(NAT_OP_COMPL);
      acc_cy(4'h6, 1'b0);
      op(NAT_OP_COMPL);
      acc_cy(4'h9, 1'b0);
    end
  endtask : s_bits
  task automatic s_load();
    op(NAT_OP_LOAD_ACC_IMM, 4'h7);
    op(NAT_OP_LOAD_ACC_IMM, 4'h2);
    op(NAT_OP_LOAD_ACC_IMM, 4'h4);
    acc_cy(4'h7, 1'b0);
    op(NAT_OP_COMPL);
    acc_cy(4'h8, 1'b0);
    chk("skip", 1'b0, skip_out);
    fetch({7'h55, 3'h0, 4'h8}, 10'h2b6, 1'b1, 3'h2);
    fetch({7'h55, 3'h2, 4'h6}, 10'h3c3, 1'b0, 3'h2);
  endtask : s_load
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    s_arith();
    s_logic();
    s_bits();
    s_load();
    conclude();
  end
  // The whole run needs some 100 cycles, so 5 us means a hang.
  initial begin
    #5000;
    err_count++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
